// File: hw/pep_pkg.sv
// pep_pkg: constants and carrier types for the parallel eeprom host controller
// assumes a 10 MHz system clock (100 ns period)
package pep_pkg;
    localparam int  CLK_NS             = 100;
    // pin timing, printed figures in their own unit
    localparam int  WRITE_PULSE_NS     = 100;
    localparam int  WRITE_HIGH_NS      = 50;
    localparam int  ADDR_HOLD_NS       = 50;
    localparam int  READ_ACCESS_NS     = 120;
    localparam int  FLOAT_NS           = 50;
    localparam int  BYTE_LOAD_WINDOW_US = 150;
    localparam int  PROGRAM_TIME_MS    = 3;
    // least times round up, longest round down
    localparam int  WP_CYC   = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int  WPH_CYC  = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int  AH_CYC   = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int  ACC_CYC  = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int  DF_CYC   = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int  BLC_CYC  = (BYTE_LOAD_WINDOW_US * 1000) / CLK_NS;
    localparam int  PROG_CYC = (PROGRAM_TIME_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int  CNT_W    = 16;
    localparam int  ADDR_W   = 15;
    localparam int  DATA_W   = 8;
    localparam int  PAGE_LSB = 6;
    localparam int  POLL_BIT = 7;
    localparam int  PAGE_MAX = 64;
    localparam int  UNLOCK_LEN = 3;

    typedef enum logic [1:0] {
        PEP_OP_READ  = 2'b00,
        PEP_OP_WRITE = 2'b01,
        PEP_OP_ERASE = 2'b10,
        PEP_OP_POLL  = 2'b11
    } pep_op_e;

    typedef struct packed {
        pep_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic                last;
        logic                unlock;
        logic [UNLOCK_LEN*(ADDR_W+DATA_W)-1:0] code;
    } pep_req_s;

    typedef struct packed {
        logic [DATA_W-1:0]   data;
        logic                page_err;
        logic                timeout;
    } pep_rsp_s;
endpackage : pep_pkg

// File: hw/pep_host.sv
// pep_host: host controller that drives a parallel eeprom through its strobes
// assumes requests synchronous to CLK; chip-erase high voltage switched externally
// How it works
// - read with chip select and output gate low, write strobe high; sample data.
// - write with chip select and write strobe low, output gate high; drive data.
// - erase lowers chip select and write strobe while the high-voltage gate is on.
// - every write strobe fall of one page load carries the same page address.
// - after the unlock code, page address held fixed on every strobe fall.
// - output gate is high whenever write strobe and chip select are low.
// - command bytes data bit seven is msb; addresses fifteen bits, line fourteen msb.
// - one to sixty-four bytes follow the unlock prefix, programmed in one period.
// - next byte of a page starts within 150 us of the previous.
`timescale 1ns/10ps
module pep_host
    import pep_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RESET_N,
    input  wire logic                  REQ_VALID,
    input  wire pep_req_s              REQ,
    output logic                       REQ_READY,
    output logic                       RSP_VALID,
    output pep_rsp_s                   RSP,
    output logic [ADDR_W-1:0]          ADDR,
    output logic [DATA_W-1:0]          DQ_OUT,
    output logic                       DQ_OE,
    input  wire logic [DATA_W-1:0]     DQ_IN,
    output logic                       CHIP_SEL_N,
    output logic                       OUT_GATE_N,
    output logic                       WRITE_N,
    output logic                       ERASE_HV
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_RSET  = 4'b0001,
        S_RWAIT = 4'b0010,
        S_FLOAT = 4'b0011,
        S_WLOW  = 4'b0100,
        S_WHIGH = 4'b0101,
        S_LOAD  = 4'b0110,
        S_POLL  = 4'b0111,
        S_EHV   = 4'b1000,
        S_ELOW  = 4'b1001,
        S_DONE  = 4'b1010
    } pep_state_e;

    pep_state_e                state;
    logic [CNT_W-1:0]          cnt;
    logic [CNT_W-1:0]          window;
    logic [15:0]               prog_cnt;
    logic [8:0]                page;
    logic                      page_open;
    logic [6:0]                nbytes;
    logic [1:0]                code_idx;
    logic                      in_code;
    pep_req_s                  cur;
    logic [DATA_W-1:0]         last_data;
    logic                      poll_read;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n > 0 ? n - 1 : 0);
    endfunction : cyc

    // current byte to put out: unlock code step or payload
    function automatic logic [ADDR_W+DATA_W-1:0] code_word(input pep_req_s r,
                                                          input logic [1:0] i);
        code_word = r.code[(UNLOCK_LEN-1-i)*(ADDR_W+DATA_W) +: ADDR_W+DATA_W];
    endfunction : code_word

    wire logic [ADDR_W+DATA_W-1:0] cw = code_word(cur, code_idx);
    wire logic [ADDR_W-1:0] out_addr = in_code ? cw[ADDR_W+DATA_W-1:DATA_W] : cur.addr;
    wire logic [DATA_W-1:0] out_data = in_code ? cw[DATA_W-1:0] : cur.data;
    wire logic page_bad = page_open && !in_code && cur.addr[ADDR_W-1:PAGE_LSB] != page;

    //////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state     <= S_IDLE;
            cnt       <= '0;
            cur       <= '0;
            code_idx  <= '0;
            in_code   <= 1'b0;
            poll_read <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (REQ_VALID) begin
                        cur      <= REQ;
                        code_idx <= '0;
                        in_code  <= REQ.op == PEP_OP_WRITE && REQ.unlock && !page_open;
                        cnt      <= '0;
                        unique case (REQ.op)
                            PEP_OP_READ, PEP_OP_POLL: begin
                                state     <= S_RSET;
                                poll_read <= REQ.op == PEP_OP_POLL;
                            end
                            PEP_OP_WRITE: state <= S_WHIGH;
                            PEP_OP_ERASE: state <= S_EHV;
                        endcase
                    end
                end
                S_RSET: begin cnt <= cyc(ACC_CYC); state <= S_RWAIT; end
                S_RWAIT: begin
                    if (cnt == '0) begin cnt <= cyc(DF_CYC); state <= S_FLOAT; end
                    else cnt <= cnt - 1'b1;
                end
                S_FLOAT: begin
                    if (cnt == '0) begin
                        // poll repeats until the poll bit matches bit seven of the last byte written or the program timer runs out
                        if (poll_read && DQ_IN[POLL_BIT] != last_data[POLL_BIT] &&
                            (prog_cnt != '0 || page_open)) state <= S_RSET;
                        else state <= S_DONE;
                    end else cnt <= cnt - 1'b1;
                end
                S_WHIGH: begin
                    if (page_bad) state <= S_DONE;
                    else if (cnt == '0) begin cnt <= cyc(WP_CYC); state <= S_WLOW; end
                    else cnt <= cnt - 1'b1;
                end
                S_WLOW: begin
                    if (cnt == '0) begin
                        // a code step stays high one cycle more so the address moves after the rise
                        cnt <= cyc(WPH_CYC > AH_CYC ? WPH_CYC : AH_CYC) + CNT_W'(in_code);
                        if (in_code && code_idx != 2'(UNLOCK_LEN - 1)) begin
                            code_idx <= code_idx + 1'b1;
                            state    <= S_WHIGH;
                        end else if (in_code) begin
                            in_code <= 1'b0;
                            state   <= S_WHIGH;
                        end else state <= S_LOAD;
                    end else cnt <= cnt - 1'b1;
                end
                S_LOAD: begin
                    if (cnt == '0) state <= S_DONE;
                    else cnt <= cnt - 1'b1;
                end
                S_EHV: begin
                    if (cnt == cyc(WP_CYC)) begin cnt <= cyc(WP_CYC); state <= S_ELOW; end
                    else cnt <= cnt + 1'b1;
                end
                S_ELOW: begin
                    if (cnt == '0) state <= S_DONE;
                    else cnt <= cnt - 1'b1;
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // page load tracking and byte load window
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            page_open <= 1'b0;
            page      <= '0;
            nbytes    <= '0;
            window    <= '0;
            last_data <= '0;
            prog_cnt  <= '0;
        end else begin
            if (prog_cnt != '0) prog_cnt <= prog_cnt - 1'b1;
            if (state == S_WLOW && cnt == '0 && !in_code) begin
                page_open <= 1'b1;
                page      <= cur.addr[ADDR_W-1:PAGE_LSB];
                nbytes    <= nbytes + 1'b1;
                last_data <= cur.data;
                window    <= CNT_W'(BLC_CYC - 2 * (WPH_CYC + WP_CYC + 2));
                if (cur.last || nbytes == 7'(PAGE_MAX - 1)) begin
                    page_open <= 1'b0;
                    nbytes    <= '0;
                    prog_cnt  <= 16'(PROG_CYC + BLC_CYC);
                end
            end else if (page_open) begin
                // the device timer runs on through reads and polls
                if (window == '0) begin
                    page_open <= 1'b0;
                    nbytes    <= '0;
                    prog_cnt  <= 16'(PROG_CYC);
                end else window <= window - 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // pins, all registered
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ADDR       <= '0;
            DQ_OUT     <= '0;
            DQ_OE      <= 1'b0;
            CHIP_SEL_N <= 1'b1;
            OUT_GATE_N <= 1'b1;
            WRITE_N    <= 1'b1;
            ERASE_HV   <= 1'b0;
        end else begin
            // address and data move only while the strobe is high, never at its rise
            if (WRITE_N && state != S_WLOW) begin
                ADDR   <= out_addr;
                DQ_OUT <= out_data;
            end
            CHIP_SEL_N <= !(state inside {S_RSET, S_RWAIT, S_WLOW, S_ELOW});
            OUT_GATE_N <= !(state inside {S_RSET, S_RWAIT});
            WRITE_N    <= !(state inside {S_WLOW, S_ELOW});
            DQ_OE      <= state inside {S_WHIGH, S_WLOW, S_LOAD} && !page_bad;
            ERASE_HV   <= state inside {S_EHV, S_ELOW};
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP       <= '0;
        end else begin
            REQ_READY <= state == S_IDLE && !REQ_VALID;
            RSP_VALID <= state == S_DONE;
            if (state == S_FLOAT && cnt == '0) RSP.data <= DQ_IN;
            if (state == S_IDLE) begin RSP.page_err <= 1'b0; RSP.timeout <= 1'b0; end
            if (state == S_WHIGH && page_bad) RSP.page_err <= 1'b1;
            if (state == S_FLOAT && cnt == '0)
                RSP.timeout <= poll_read && DQ_IN[POLL_BIT] != last_data[POLL_BIT];
        end
    end
endmodule : pep_host

// File: tb/pep_checker.sv
// pep_checker: strobe and bus-direction checks on the host pins
// assumes bound into pep_host and sees only its ports
`timescale 1ns/10ps
module pep_checker
    import pep_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RESET_N,
    input wire logic              RSP_VALID,
    input wire pep_rsp_s          RSP,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] DQ_OUT,
    input wire logic              DQ_OE,
    input wire logic              CHIP_SEL_N,
    input wire logic              OUT_GATE_N,
    input wire logic              WRITE_N,
    input wire logic              ERASE_HV
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_read_float: assert property (!OUT_GATE_N |-> !DQ_OE)
        else $error("host drives data while output gate low");
    a_read_noweb: assert property (!OUT_GATE_N && !ERASE_HV |-> WRITE_N)
        else $error("write strobe low while output gate low");
    a_write_gate: assert property (!WRITE_N && !CHIP_SEL_N && !ERASE_HV |-> OUT_GATE_N && DQ_OE)
        else $error("write without output gate high and data driven");
    a_erase_sel: assert property (ERASE_HV && !WRITE_N |-> !CHIP_SEL_N)
        else $error("erase strobe without chip select");
    a_hv_first: assert property ($fell(WRITE_N) && ERASE_HV |-> $past(ERASE_HV))
        else $error("erase voltage not raised before strobe");
    a_addr_setup: assert property ($fell(WRITE_N) |-> $stable(ADDR) && $stable(DQ_OUT))
        else $error("address or data moved at strobe fall");
    a_addr_hold: assert property ($rose(WRITE_N) |-> $stable(ADDR) && $stable(DQ_OUT))
        else $error("address hold after strobe rise too short");
    a_refuse_quiet: assert property (RSP_VALID && RSP.page_err |->
        $past(WRITE_N, 1) && $past(WRITE_N, 2) && $past(WRITE_N, 3))
        else $error("refused write still strobed");
    c_erase: cover property (ERASE_HV && !WRITE_N);
    c_refuse: cover property (RSP_VALID && RSP.page_err);
    c_read: cover property (!OUT_GATE_N && !CHIP_SEL_N);
endmodule : pep_checker

// File: tb/pep_mem_model.sv
// pep_mem_model: behavioural parallel eeprom seen from its pins
// assumes host strobes change on clk edges; clk paces the timers and samples the strobes
`timescale 1ns/10ps
module pep_mem_model
    import pep_pkg::*;
#(
    parameter int BLC  = 1500,
    parameter int PROG = 300
)(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic              dq_oe,
    output logic      [DATA_W-1:0] dq_in,
    input  wire logic              chip_sel_n,
    input  wire logic              out_gate_n,
    input  wire logic              write_n,
    input  wire logic              erase_hv
);
    logic [DATA_W-1:0]   mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]   page [0:PAGE_MAX-1];
    logic [PAGE_MAX-1:0] hit = '0;
    logic [ADDR_W-1:0]   la = '0;
    logic [DATA_W-1:0]   ld = '0;
    logic [DATA_W-1:0]   held = '0;
    int                  win = 0;
    int                  busy = 0;
    // newest strobed word first, kept for the bench
    logic [ADDR_W+DATA_W-1:0] seen [0:UNLOCK_LEN];
    wire                 rd = !chip_sel_n && !out_gate_n && write_n;
    wire                 wr = !chip_sel_n && !write_n && out_gate_n && !erase_hv;
    wire [DATA_W-1:0]    din = dq_oe ? dq_out : ~dq_out;
    wire [DATA_W-1:0]    val = ((busy > 0 || win > 0) && addr == la) ?
                               {~ld[7], ld[6:0]} : mem[addr];
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // released bus shows the inverse of the last value, never a stale copy
    assign dq_in = rd ? val : ~held;
    always @(posedge clk) begin
        if (rd) held <= val;
        if (wr) begin
            seen[0] <= {addr, din};
            for (int i = 1; i <= UNLOCK_LEN; i++) seen[i] <= seen[i-1];
        end
        if (!chip_sel_n && !write_n && erase_hv) begin
            foreach (mem[i]) mem[i] <= 8'hFF;
        end else if (wr && busy == 0) begin
            la <= addr;
            ld <= din;
            page[addr[5:0]] <= din;
            hit[addr[5:0]] <= 1'b1;
            win <= BLC;
        end else if (win == 1) begin
            for (int i = 0; i < PAGE_MAX; i++)
                if (hit[i]) mem[{la[ADDR_W-1:PAGE_LSB], 6'(i)}] <= page[i];
            hit <= '0;
            win <= 0;
            busy <= PROG;
        end else if (win > 1) win <= win - 1;
        else if (busy > 0) busy <= busy - 1;
    end
endmodule : pep_mem_model

// File: tb/pep_host_test.sv
// pep_host_test: directed bench for the eeprom host against the memory model
// assumes pep_pkg, pep_host, pep_mem_model and pep_checker compiled first
`timescale 1ns/10ps
module pep_host_test
    import pep_pkg::*;
;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              req_valid = 1'b0;
    pep_req_s          req = '0;
    pep_rsp_s          rsp;
    logic              req_ready, rsp_valid, dq_oe, chip_sel_n, out_gate_n, write_n, erase_hv;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out, dq_in;
    int                err_total = 0;
    int                total_checks = 0;
    always #50 clk = ~clk;
    pep_host pep_host_i (.CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ(req),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP(rsp), .ADDR(addr), .DQ_OUT(dq_out),
        .DQ_OE(dq_oe), .DQ_IN(dq_in), .CHIP_SEL_N(chip_sel_n), .OUT_GATE_N(out_gate_n),
        .WRITE_N(write_n), .ERASE_HV(erase_hv));
    pep_mem_model #(.BLC(BLC_CYC), .PROG(300)) pep_mem_model_i (.clk, .addr, .dq_out, .dq_oe,
        .dq_in, .chip_sel_n, .out_gate_n, .write_n, .erase_hv);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chkw(input logic [ADDR_W+DATA_W-1:0] got,
                        input logic [ADDR_W+DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkw
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chkw({15'h0000, got}, {15'h0000, exp});
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic go_req(input pep_req_s r);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= r;
        @(negedge clk);
        chk1(req_ready, 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        do @(negedge clk); while (rsp_valid !== 1'b1);
    endtask : go_req
    task automatic go(input pep_op_e o, input logic [14:0] a, input logic [7:0] d, input logic l);
        go_req('{op: o, addr: a, data: d, last: l, unlock: 1'b0, code: '0});
    endtask : go
    task automatic poll(input logic [14:0] a, input logic [7:0] d);
        go(PEP_OP_POLL, a, d, 1'b0);
        chk1(rsp.timeout, 1'b0);
        chk8(rsp.data, d);
    endtask : poll
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] d);
        go(PEP_OP_READ, a, 8'h00, 1'b0);
        chk8(rsp.data, d);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_full_page;
        for (int i = 0; i < PAGE_MAX; i++) begin
            go(PEP_OP_WRITE, 15'h0100 + 15'(i), 8'(i) ^ 8'hA5, 1'b0);
            chk1(rsp.page_err, 1'b0);
        end
        poll(15'h013F, 8'h9A);
        for (int i = 0; i < PAGE_MAX; i++) rd_chk(15'h0100 + 15'(i), 8'(i) ^ 8'hA5);
    endtask : t_full_page
    task automatic t_refuse;
        go(PEP_OP_WRITE, 15'h0200, 8'h11, 1'b0);
        chk1(rsp.page_err, 1'b0);
        go(PEP_OP_WRITE, 15'h0300, 8'h22, 1'b0);
        chk1(rsp.page_err, 1'b1);
        go(PEP_OP_WRITE, 15'h0201, 8'h33, 1'b1);
        chk1(rsp.page_err, 1'b0);
        poll(15'h0201, 8'h33);
        rd_chk(15'h0300, 8'hFF);
        rd_chk(15'h0200, 8'h11);
    endtask : t_refuse
    task automatic t_window;
        go(PEP_OP_WRITE, 15'h0400, 8'h80, 1'b0);
        poll(15'h0400, 8'h80);
        rd_chk(15'h0400, 8'h80);
    endtask : t_window
    task automatic t_unlock;
        go_req('{op: PEP_OP_WRITE, addr: 15'h0600, data: 8'h6D, last: 1'b1, unlock: 1'b1,
            code: {15'h0711, 8'h3C, 15'h0722, 8'hC3, 15'h0733, 8'h5A}});
        chk1(rsp.page_err, 1'b0);
        chkw(pep_mem_model_i.seen[3], {15'h0711, 8'h3C});
        chkw(pep_mem_model_i.seen[2], {15'h0722, 8'hC3});
        chkw(pep_mem_model_i.seen[1], {15'h0733, 8'h5A});
        chkw(pep_mem_model_i.seen[0], {15'h0600, 8'h6D});
        poll(15'h0600, 8'h6D);
        rd_chk(15'h0600, 8'h6D);
    endtask : t_unlock
    task automatic t_erase;
        go(PEP_OP_ERASE, 15'h0000, 8'h00, 1'b0);
        rd_chk(15'h0200, 8'hFF);
        rd_chk(15'h0400, 8'hFF);
        rd_chk(15'h0600, 8'hFF);
    endtask : t_erase
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(15'h0123, 8'hFF);
        t_full_page();
        t_refuse();
        t_window();
        t_unlock();
        t_erase();
        test_done();
    end
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        test_done();
    end
endmodule : pep_host_test
bind pep_host pep_checker pep_checker_i (.CLK, .RESET_N, .RSP_VALID, .RSP, .ADDR, .DQ_OUT,
    .DQ_OE, .CHIP_SEL_N, .OUT_GATE_N, .WRITE_N, .ERASE_HV);
